// *** core/idmac_defines.svh ***
// Offsets, field positions, reset values and sizes of the bus-master DMA channel control.
`ifndef IDMAC_DEFINES_SVH
`define IDMAC_DEFINES_SVH

// Register offsets within the bus-master base address window.
`define IDMAC_CMD_OFF         8'h08
`define IDMAC_STS_OFF         8'h0a

// Command register fields.
`define IDMAC_CMD_START_BIT   0
`define IDMAC_CMD_DIR_BIT     3
`define IDMAC_CMD_FPACT_BIT   8
`define IDMAC_CMD_FPDIR_BIT   9
`define IDMAC_CMD_RESET       16'h0000

// Status register fields.
`define IDMAC_STS_ACTIVE_BIT  0
`define IDMAC_STS_ERR_BIT     1
`define IDMAC_STS_IRQ_BIT     2
`define IDMAC_STS_CAP0_BIT    5
`define IDMAC_STS_CAP1_BIT    6
`define IDMAC_STS_SIMPLEX_BIT 7
`define IDMAC_CAP_RESET       1'b1

// Register port sizes and data path defaults.
`define IDMAC_ADDR_W          8
`define IDMAC_REG_W           16
`define IDMAC_DATA_W          32
`define IDMAC_FIFO_DEPTH      8

`endif

// *** core/idmac_pkg.sv ***
// Types shared by the bus-master DMA channel control, its checker and its bench.
`include "idmac_defines.svh"

package idmac_pkg;

  typedef struct packed {
    logic                      rd;
    logic                      wr;
    logic [`IDMAC_ADDR_W-1:0]  addr;
    logic [`IDMAC_REG_W-1:0]   wdata;
  } idmac_reg_req_t;

  typedef struct packed {
    logic active;
    logic dir;
  } idmac_fpdma_t;

endpackage

// *** core/idmac_fifo.sv ***
// Synchronous FIFO with registered valid and ready flags and a flush input.
`include "idmac_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module idmac_fifo #(
  parameter int WIDTH = `IDMAC_DATA_W,
  parameter int DEPTH = `IDMAC_FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("idmac_fifo needs a power-of-two DEPTH of at least 2 and WIDTH of at least 1.");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  wire              push;
  wire              pop;

  assign push     = in_valid & in_ready & ~flush;
  assign pop      = out_valid & out_ready & ~flush;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    if (flush) begin
      count_next = '0;
    end else begin
      count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
    end else begin
      wr_ptr_reg <= flush ? '0 : wr_ptr_reg + AW'(push);
      rd_ptr_reg <= flush ? '0 : rd_ptr_reg + AW'(pop);
      count_reg  <= count_next;
      in_ready   <= ~flush & (count_next != FULL_CNT);
      out_valid  <= ~flush & (count_next != '0);
    end
  end

endmodule

`default_nettype wire

// *** core/idmac_channel.sv ***
// Command and status control of one bus-master IDE DMA channel with its data buffer.
//
// What this block does
// [R01] Software picks direction with command bit 3 and leaves it alone while running.
// [R02] Direction bit ignores writes while the channel is active; writable again afterwards.
// [R03] Writing 1 to command bit 0 starts the DMA; the bit resets to stop.
// [R04] Data moves only while the start bit holds 1.
// [R05] Writing 0 to start stops and discards all engine state; no resume.
// [R06] Clearing start while active and unfinished aborts; buffered drive data may drop.
// [R07] Software should clear start only after status bit 0 or 2 shows completion.
// [R08] Status register sits at offset 0AH of the bus-master window.
// [R09] Command bit 9 reports first-party DMA direction, 1 meaning host to device.
// [R10] Command bit 8 reports first-party DMA active; resets to 0.
// [R11] Status bit 2 sets on drive interrupt; software clears it by writing 1.
// [R12] Status bit 0 sets with start; clears on last descriptor or start cleared.
// [R13] Reserved command bits read zero and writes to them have no effect.
`include "idmac_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module idmac_channel
  import idmac_pkg::*;
#(
  parameter int DATA_W     = `IDMAC_DATA_W,
  parameter int FIFO_DEPTH = `IDMAC_FIFO_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire idmac_reg_req_t           reg_req,
  output var  logic [`IDMAC_REG_W-1:0]  reg_rdata,
  input  wire logic                     src_valid,
  input  wire logic [DATA_W-1:0]        src_data,
  output var  logic                     src_ready,
  output var  logic                     snk_valid,
  output logic      [DATA_W-1:0]        snk_data,
  input  wire logic                     snk_ready,
  input  wire logic                     drive_irq_pin,
  input  wire logic                     last_desc_done,
  input  wire logic                     bus_error,
  input  wire idmac_fpdma_t             fpdma_state,
  output var  logic                     xfer_write,
  output var  logic                     engine_run,
  output var  logic                     engine_abort
);

  generate
    if (DATA_W < 8) begin : g_bad_width
      $error("idmac_channel needs DATA_W of at least 8.");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////////

  logic       start_reg;
  logic       start_next;
  logic       dir_reg;
  logic       dir_next;
  logic       active_reg;
  logic       active_next;
  logic       irq_flag_reg;
  logic       irq_flag_next;
  logic       err_flag_reg;
  logic       err_flag_next;
  logic [1:0] cap_reg;
  logic [1:0] cap_next;
  logic       fp_active_reg;
  logic       fp_dir_reg;
  logic       irq_sync1_reg;
  logic       irq_sync2_reg;
  logic       irq_seen_reg;
  logic       abort_next;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire cmd_sel  = (reg_req.addr == `IDMAC_CMD_OFF);
  wire sts_sel  = (reg_req.addr == `IDMAC_STS_OFF); // [R08]
  wire cmd_wr   = reg_req.wr & cmd_sel;
  wire sts_wr   = reg_req.wr & sts_sel;
  wire wr_start = reg_req.wdata[`IDMAC_CMD_START_BIT];
  wire wr_dir   = reg_req.wdata[`IDMAC_CMD_DIR_BIT];

  // A start only counts on a 0 to 1 change; rewriting 1 while running does not restart the transfer.
  wire start_rise = cmd_wr & wr_start & ~start_reg; // [R03]
  wire stop_req   = cmd_wr & ~wr_start & start_reg; // [R05]

  // The drive interrupt is counted once per rising edge after synchronising.
  wire irq_rise = irq_sync2_reg & ~irq_seen_reg;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the command and status fields.

  // Only bits 0 and 3 of a command write are stored; reserved bits fall away.
  assign start_next = cmd_wr ? wr_start : start_reg; // [R03] [R13]

  // The direction stays frozen while the channel is active.
  assign dir_next = (cmd_wr & ~active_reg) ? wr_dir : dir_reg; // [R02]

  always_comb begin
    if (start_rise) begin
      active_next = 1'b1; // [R12]
    end else if (last_desc_done | stop_req) begin
      active_next = 1'b0; // [R12]
    end else begin
      active_next = active_reg;
    end
  end

  // A hardware set wins over a software clear arriving in the same cycle.
  always_comb begin
    if (irq_rise) begin
      irq_flag_next = 1'b1; // [R11]
    end else if (sts_wr & reg_req.wdata[`IDMAC_STS_IRQ_BIT]) begin
      irq_flag_next = 1'b0; // [R11]
    end else begin
      irq_flag_next = irq_flag_reg;
    end
  end

  always_comb begin
    if (bus_error & active_reg) begin
      err_flag_next = 1'b1;
    end else if (sts_wr & reg_req.wdata[`IDMAC_STS_ERR_BIT]) begin
      err_flag_next = 1'b0;
    end else begin
      err_flag_next = err_flag_reg;
    end
  end

  assign cap_next = sts_wr ? {reg_req.wdata[`IDMAC_STS_CAP1_BIT], reg_req.wdata[`IDMAC_STS_CAP0_BIT]} : cap_reg;

  // Stopping an active, unfinished transfer aborts it and flushes the buffer.
  assign abort_next = stop_req & active_reg & ~irq_flag_reg; // [R06]

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [`IDMAC_REG_W-1:0] cmd_view;
  logic [`IDMAC_REG_W-1:0] sts_view;
  wire [`IDMAC_REG_W-1:0] rd_mux;

  always_comb begin
    cmd_view = '0; // [R13]
    cmd_view[`IDMAC_CMD_START_BIT] = start_reg;
    cmd_view[`IDMAC_CMD_DIR_BIT]   = dir_reg;
    cmd_view[`IDMAC_CMD_FPACT_BIT] = fp_active_reg; // [R10]
    cmd_view[`IDMAC_CMD_FPDIR_BIT] = fp_dir_reg; // [R09]
  end

  always_comb begin
    sts_view = '0;
    sts_view[`IDMAC_STS_ACTIVE_BIT] = active_reg; // [R12]
    sts_view[`IDMAC_STS_ERR_BIT]    = err_flag_reg;
    sts_view[`IDMAC_STS_IRQ_BIT]    = irq_flag_reg; // [R11]
    sts_view[`IDMAC_STS_CAP0_BIT]   = cap_reg[0];
    sts_view[`IDMAC_STS_CAP1_BIT]   = cap_reg[1];
  end

  assign rd_mux = cmd_sel ? cmd_view : (sts_sel ? sts_view : '0);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg    <= 1'b0;
      dir_reg      <= 1'b0;
      active_reg   <= 1'b0;
      irq_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
      cap_reg      <= {2{`IDMAC_CAP_RESET}};
    end else begin
      start_reg    <= start_next;
      dir_reg      <= dir_next;
      active_reg   <= active_next;
      irq_flag_reg <= irq_flag_next;
      err_flag_reg <= err_flag_next;
      cap_reg      <= cap_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_active_reg <= 1'b0;
      fp_dir_reg    <= 1'b0;
    end else begin
      fp_active_reg <= fpdma_state.active; // [R10]
      fp_dir_reg    <= fpdma_state.dir; // [R09]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sync1_reg <= 1'b0;
      irq_sync2_reg <= 1'b0;
      irq_seen_reg  <= 1'b0;
    end else begin
      irq_sync1_reg <= drive_irq_pin;
      irq_sync2_reg <= irq_sync1_reg;
      irq_seen_reg  <= irq_sync2_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= '0;
      xfer_write   <= 1'b0;
      engine_run   <= 1'b0;
      engine_abort <= 1'b0;
    end else begin
      reg_rdata    <= reg_req.rd ? rd_mux : '0;
      xfer_write   <= dir_next;
      engine_run   <= start_next; // [R04]
      engine_abort <= abort_next; // [R06]
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Data buffer, held flushed whenever the start bit is clear.

  idmac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (~start_reg), // [R04] [R05]
    .in_valid  (src_valid),
    .in_data   (src_data),
    .in_ready  (src_ready),
    .out_valid (snk_valid),
    .out_data  (snk_data),
    .out_ready (snk_ready)
  );

endmodule

`default_nettype wire

// *** bench/idmac_channel_properties.sv ***
// Checker of the DMA channel control ports, bound to the channel.
`include "idmac_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module idmac_channel_chk import idmac_pkg::*; #(parameter int DATA_W = 32) (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire idmac_reg_req_t     reg_req,
  input wire logic [15:0]        reg_rdata,
  input wire logic               src_valid,
  input wire logic [DATA_W-1:0]  src_data,
  input wire logic               src_ready,
  input wire logic               snk_valid,
  input wire logic [DATA_W-1:0]  snk_data,
  input wire logic               snk_ready,
  input wire logic               drive_irq_pin,
  input wire logic               last_desc_done,
  input wire logic               bus_error,
  input wire idmac_fpdma_t       fpdma_state,
  input wire logic               xfer_write,
  input wire logic               engine_run,
  input wire logic               engine_abort
);
  wire logic cw = reg_req.wr && reg_req.addr == `IDMAC_CMD_OFF;
  wire logic cr = reg_req.rd && reg_req.addr == `IDMAC_CMD_OFF;
  wire logic sr = reg_req.rd && reg_req.addr == `IDMAC_STS_OFF;
  wire logic st = reg_req.wdata[0];
  logic      act_reg;
  // Mirrors the active flag: a start rise sets it, last descriptor or stop clears it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) act_reg <= 1'b0;
    else if (cw && st && !engine_run) act_reg <= 1'b1;
    else if (last_desc_done || (cw && !st)) act_reg <= 1'b0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_start_runs: assert property (cw && st |=> engine_run) else $error("start lost");
  a_stop_halts: assert property (cw && !st |=> !engine_run ##1 (!src_ready && !snk_valid))
    else $error("stop lost");
  a_stopped_idle: assert property (!engine_run && !$past(engine_run) |-> !src_ready && !snk_valid)
    else $error("moving while stopped");
  a_dir_locked: assert property (cw && act_reg |=> $stable(xfer_write)) else $error("dir changed");
  a_dir_free: assert property (cw && !act_reg |=> xfer_write == $past(reg_req.wdata[3]))
    else $error("dir not written");
  a_abort_cause: assert property (engine_abort |-> $past(cw && !st && act_reg)) else $error("bad abort");
  a_cmd_mirror: assert property (cr |=> reg_rdata == {6'h00, $past(fpdma_state.dir, 2),
    $past(fpdma_state.active, 2), 4'h0, $past(xfer_write), 2'h0, $past(engine_run)}) else $error("cmd read");
  a_status_active: assert property (sr |=> reg_rdata[0] == $past(act_reg) && reg_rdata[15:7] == '0)
    else $error("status read");
  c_abort: cover property (engine_abort);
  c_full: cover property (engine_run && $past(engine_run) && !src_ready);
  c_pop: cover property (snk_valid && snk_ready);
endmodule
bind idmac_channel idmac_channel_chk #(.DATA_W(DATA_W)) chk_u (.*);
`default_nettype wire

// *** bench/idmac_xfer_model.sv ***
// Drive and memory side model: offers counted words and takes them back with stalls.
`timescale 1ns/100ps
`default_nettype none
module idmac_xfer_model (
  input  wire logic        sys_clk,
  input  wire logic        engine_run,
  input  wire logic        send,
  input  wire logic        stall,
  output var  logic        src_valid,
  output var  logic [31:0] src_data,
  input  wire logic        src_ready,
  input  wire logic        snk_valid,
  input  wire logic [31:0] snk_data,
  output var  logic        snk_ready,
  output var  int          sent,
  output var  int          got,
  output var  int          bad
);
  initial begin
    {src_valid, snk_ready, sent, got, bad} = '0;
    src_data = 32'hffff_ffff;
  end
  // A flush drops buffered words, so the expected sequence restarts at the next offered word.
  always @(posedge sys_clk) begin
    if (!engine_run) got <= sent;
    else if (snk_valid && snk_ready) begin
      if (snk_data !== 32'h1357_0000 + got) bad <= bad + 1;
      got <= got + 1;
    end
    if (src_valid && src_ready) sent <= sent + 1;
  end
  // Data advances only after acceptance and toggles while nothing is offered.
  always @(negedge sys_clk) begin
    src_valid <= send;
    src_data <= send ? 32'h1357_0000 + sent : ~src_data;
    snk_ready <= !stall;
  end
endmodule
`default_nettype wire

// *** bench/idmac_channel_tb_top.sv ***
// Self-checking bench of the DMA channel control with a drive and memory model.
`timescale 1ns/100ps
`default_nettype none
module idmac_channel_tb_top import idmac_pkg::*; ();
  logic           sys_clk, rst_n, src_valid, src_ready, snk_valid, snk_ready, xfer_write;
  logic           engine_run, engine_abort, drive_irq_pin, last_desc_done, bus_error, send, stall, ab;
  logic [15:0]    reg_rdata, d;
  logic [31:0]    src_data, snk_data;
  logic [7:0]     a;
  idmac_reg_req_t reg_req;
  idmac_fpdma_t   fpdma_state;
  int             sent, got, bad, num_errors, checks_done, seed, i;
  idmac_channel dut_u (.*);
  idmac_xfer_model model_u (.*);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_cnt(input int seen, input int exp, input string what);
    checks_done++;
    if (seen != exp) begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xact(input logic r, input logic w, input logic [7:0] ad, input logic [15:0] wd);
    reg_req = '{rd: r, wr: w, addr: ad, wdata: wd};
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] wd);
    xact(1'b0, 1'b1, ad, wd);
    xact(1'b0, 1'b0, ad, 16'h0000);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [15:0] m, input logic [15:0] e, input string what);
    xact(1'b1, 1'b0, ad, 16'h0000);
    chk(reg_rdata & m, e, what);
    xact(1'b0, 1'b0, ad, 16'h0000);
  endtask
  // Writes stop to the command register and watches the one-cycle abort pulse from its first cycle on.
  task automatic abort_seen();
    xact(1'b0, 1'b1, 8'h08, 16'h0000);
    ab = engine_abort;
    repeat (2) begin
      xact(1'b0, 1'b0, 8'h08, 16'h0000);
      ab = ab | engine_abort;
    end
  endtask
  task automatic settle();
    for (int k = 0; k < 80 && got != sent; k++) @(negedge sys_clk);
    if (got != sent) begin
      num_errors++;
      print_verdict();
    end
  endtask
  function automatic logic [15:0] cmd_exp(input idmac_fpdma_t f, input logic [15:0] wd);
    return {6'h00, f.dir, f.active, 4'h0, wd[3], 3'h0};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    seed = 42;
    reg_req = '0;
    fpdma_state = '0;
    {drive_irq_pin, last_desc_done, bus_error, send, stall} = '0;
    rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    rdc(8'h08, 16'hffff, 16'h0000, "cmd reset");
    rdc(8'h0a, 16'hffff, 16'h0060, "status reset");
    $display("test 1 done");
    for (i = 0; i < 12; i++) begin
      fpdma_state = idmac_fpdma_t'(2'($random(seed)));
      d = 16'($random(seed)) & 16'hfffe;
      a = 8'h10 | 8'($random(seed));
      xact(1'b0, 1'b1, 8'h08, d);
      xact(1'b0, 1'b1, a, 16'hffff);
      rdc(a, 16'hffff, 16'h0000, "unmapped read");
      rdc(8'h08, 16'hffff, cmd_exp(fpdma_state, d), "cmd fields");
    end
    wr(8'h0a, 16'h0000);
    rdc(8'h0a, 16'hffff, 16'h0000, "caps cleared");
    wr(8'h0a, 16'h0060);
    rdc(8'h0a, 16'hffff, 16'h0060, "caps set");
    $display("test 2 done");
    wr(8'h08, 16'h0009);
    rdc(8'h0a, 16'h0001, 16'h0001, "active");
    wr(8'h08, 16'h0001);
    rdc(8'h08, 16'h000f, 16'h0009, "dir locked");
    stall <= 1'b1;
    send <= 1'b1;
    repeat (16) @(negedge sys_clk);
    chk({15'h0000, src_ready}, 16'h0000, "ready when full");
    chk_cnt(sent - got, 8, "words buffered");
    stall <= 1'b0;
    send <= 1'b0;
    settle();
    chk_cnt(bad, 0, "word order");
    last_desc_done = 1'b1;
    @(negedge sys_clk);
    last_desc_done = 1'b0;
    rdc(8'h0a, 16'h0001, 16'h0000, "active after last");
    wr(8'h08, 16'h0001);
    rdc(8'h08, 16'h000f, 16'h0001, "dir free");
    abort_seen();
    chk({15'h0000, ab}, 16'h0000, "abort when done");
    $display("test 3 done");
    wr(8'h08, 16'h0001);
    stall <= 1'b1;
    send <= 1'b1;
    repeat (5) @(negedge sys_clk);
    bus_error = 1'b1;
    @(negedge sys_clk);
    bus_error = 1'b0;
    rdc(8'h0a, 16'h0002, 16'h0002, "error flag");
    abort_seen();
    chk({15'h0000, ab}, 16'h0001, "abort");
    chk({14'h0000, src_ready, snk_valid}, 16'h0000, "flushed");
    wr(8'h0a, 16'h0062);
    rdc(8'h0a, 16'hffff, 16'h0060, "error cleared");
    wr(8'h08, 16'h0001);
    stall <= 1'b0;
    repeat (10) @(negedge sys_clk);
    send <= 1'b0;
    settle();
    chk_cnt(bad, 0, "restart order");
    $display("test 4 done");
    drive_irq_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    rdc(8'h0a, 16'h0005, 16'h0005, "irq flag");
    abort_seen();
    chk({15'h0000, ab}, 16'h0000, "abort after irq");
    drive_irq_pin = 1'b0;
    wr(8'h0a, 16'h0064);
    rdc(8'h0a, 16'h0005, 16'h0000, "irq cleared");
    $display("test 5 done");
    print_verdict();
  end
endmodule
`default_nettype wire
